// ==== phy_mgmt_defines.svh ====
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH

// Register indexes
`define IDX_BASIC_CONTROL  5'h00
`define IDX_BASIC_STATUS   5'h01
`define IDX_IDENT_HIGH     5'h02
`define IDX_IDENT_LOW      5'h03
`define IDX_AUTONEG_ADV    5'h04

// Control register
`define CTRL_RESET_VALUE   16'h3000
`define CTRL_WRITE_MASK    16'hFB80
`define CTRL_SOFT_RESET    15
`define CTRL_RESTART_AN    9

// Status register fixed bits
`define STAT_FIXED_VALUE   16'h7809

// Advertisement register
`define ADV_RESET_VALUE    16'h01E1
`define ADV_WRITE_MASK     16'hBFFF
`define PAUSE_NONE         2'h0
`define PAUSE_SYM          2'h1
`define PAUSE_ASYM         2'h2
`define PAUSE_BOTH         2'h3

// Soft reset timing
`define CLK_PERIOD_NS      4
`define SOFT_RESET_NS      400
`define SOFT_RESET_CYCLES  ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== phy_mgmt_pkg.sv ====
package phy_mgmt_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  index;
    logic [15:0] data;
  } mgmt_req_t;

  typedef struct packed {
    logic       softReset;
    logic       loopback;
    logic       speed100;
    logic       anEnable;
    logic       powerDown;
    logic       rsvd10;
    logic       anRestart;
    logic       fullDuplex;
    logic       colTest;
    logic [6:0] rsvdLow;
  } basic_ctrl_t;

  typedef struct packed {
    logic softResetActive;
    logic loopback;
    logic speed100;
    logic fullDuplex;
    logic anEnable;
    logic powerDown;
    logic collisionTest;
    logic anRestart;
    logic pauseSym;
    logic pauseAsym;
  } xcvr_ctrl_t;

  typedef enum logic {
    SR_IDLE = 1'b0,
    SR_BUSY = 1'b1
  } soft_reset_state_t;

endpackage

// ==== sync_two_flop.sv ====
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule

// ==== phy_basic_mgmt_registers.sv ====
`timescale 1ns/1ps
`include "phy_mgmt_defines.svh"
module phy_basic_mgmt_registers
  import phy_mgmt_pkg::*;
#(
  parameter int          SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES,
  // Arbitrary identifier values
  parameter logic [15:0] IDENT_HIGH_RESET  = 16'h1234,
  parameter logic [15:0] IDENT_LOW_RESET   = 16'h5678
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Management access
  input  wire mgmt_req_t  mgmtReq,
  output logic [15:0]     rdData,
  output logic            rdValid,
  // Transceiver status pins
  input  wire logic       linkUpPin,
  input  wire logic       jabberPin,
  input  wire logic       remoteFaultPin,
  input  wire logic       anCompletePin,
  input  wire logic       anSpeed100Pin,
  input  wire logic       anFullDuplexPin,
  input  wire logic [1:0] partnerPausePin,
  // Transceiver control
  output xcvr_ctrl_t      xcvrCtrl,
  output logic [15:0]     advertWord
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int NUM_PINS = 8;

  logic [NUM_PINS-1:0] pinSync;
  logic                linkSync;
  logic                jabberSync;
  logic                faultSync;
  logic                anDoneSync;
  logic                anSpeedSync;
  logic                anDuplexSync;
  logic [1:0]          partnerPause;

  sync_two_flop #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({linkUpPin, jabberPin, remoteFaultPin, anCompletePin,
               anSpeed100Pin, anFullDuplexPin, partnerPausePin}),
    .syncOut (pinSync)
  );

  assign linkSync     = pinSync[7];
  assign jabberSync   = pinSync[6];
  assign faultSync    = pinSync[5];
  assign anDoneSync   = pinSync[4];
  assign anSpeedSync  = pinSync[3];
  assign anDuplexSync = pinSync[2];
  assign partnerPause = pinSync[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Index decode

  logic wrCtrl;
  logic wrIdHigh;
  logic wrIdLow;
  logic wrAdv;
  logic rdStatus;
  logic srIdle;
  logic srStart;

  soft_reset_state_t srState_q;
  soft_reset_state_t srState_d;

  assign srIdle   = (srState_q == SR_IDLE);
  assign wrCtrl   = mgmtReq.wr && (mgmtReq.index == `IDX_BASIC_CONTROL) && srIdle;
  assign wrIdHigh = mgmtReq.wr && (mgmtReq.index == `IDX_IDENT_HIGH);
  assign wrIdLow  = mgmtReq.wr && (mgmtReq.index == `IDX_IDENT_LOW);
  assign wrAdv    = mgmtReq.wr && (mgmtReq.index == `IDX_AUTONEG_ADV) && srIdle;
  assign rdStatus = mgmtReq.rd && (mgmtReq.index == `IDX_BASIC_STATUS);
  assign srStart  = wrCtrl && mgmtReq.data[`CTRL_SOFT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer

  logic [15:0] srCount_q;
  logic [15:0] srCount_d;
  logic        srDone;

  assign srDone = (srState_q == SR_BUSY) && (srCount_q == 16'h0000);

  always_comb begin
    srState_d = srState_q;
    srCount_d = srCount_q;
    case (srState_q)
      SR_IDLE: begin
        if (srStart) begin
          srState_d = SR_BUSY;
          srCount_d = 16'(SOFT_RESET_CYCLES - 1);
        end
      end
      SR_BUSY: begin
        if (srDone) begin
          srState_d = SR_IDLE;
        end else begin
          srCount_d = srCount_q - 16'h0001;
        end
      end
      default: begin
        srState_d = SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srState_q <= SR_IDLE;
      srCount_q <= 16'h0000;
    end else begin
      srState_q <= srState_d;
      srCount_q <= srCount_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  basic_ctrl_t ctrl_q;
  basic_ctrl_t ctrl_d;
  logic [15:0] ctrlWrite;
  logic        anRestart_q;
  logic        anRestart_d;

  assign ctrlWrite   = mgmtReq.data & `CTRL_WRITE_MASK;
  assign ctrl_d      = srDone ? basic_ctrl_t'(`CTRL_RESET_VALUE) :
                       (wrCtrl && !srStart) ? basic_ctrl_t'(ctrlWrite) :
                       ctrl_q;
  assign anRestart_d = wrCtrl && !srStart && mgmtReq.data[`CTRL_RESTART_AN];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= basic_ctrl_t'(`CTRL_RESET_VALUE);
      anRestart_q <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      anRestart_q <= anRestart_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identifier registers

  logic [15:0] idHigh_q;
  logic [15:0] idLow_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idHigh_q <= IDENT_HIGH_RESET;
      idLow_q  <= IDENT_LOW_RESET;
    end else begin
      if (wrIdHigh) begin
        idHigh_q <= mgmtReq.data;
      end
      if (wrIdLow) begin
        idLow_q <= mgmtReq.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement register

  logic [15:0] adv_q;
  logic [15:0] adv_d;

  assign adv_d = srDone ? `ADV_RESET_VALUE :
                 wrAdv  ? (mgmtReq.data & `ADV_WRITE_MASK) :
                 adv_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adv_q <= `ADV_RESET_VALUE;
    end else begin
      adv_q <= adv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latching status bits: fault, jabber high; link low

  logic [2:0] latch_q;
  logic [2:0] latch_d;
  logic [2:0] latchEvent;
  logic [2:0] latchLow;

  assign latchEvent = {faultSync, jabberSync, linkSync};
  assign latchLow   = 3'h1;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_latch
      assign latch_d[gi] = latchLow[gi] ?
                           (latchEvent[gi] && (latch_q[gi] || rdStatus)) :
                           (latchEvent[gi] || (latch_q[gi] && !rdStatus));
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 3'h0;
    end else begin
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [15:0] statusWord;
  logic [15:0] ctrlWord;
  logic [15:0] readMux;

  assign ctrlWord   = {!srIdle, ctrl_q.loopback, ctrl_q.speed100, ctrl_q.anEnable,
                       ctrl_q.powerDown, 1'b0, anRestart_q, ctrl_q.fullDuplex,
                       ctrl_q.colTest, 7'h00};
  assign statusWord = `STAT_FIXED_VALUE |
                      {10'h000, anDoneSync, latch_q[2], 1'b0, latch_q[0], latch_q[1], 1'b0};
  assign readMux    = (mgmtReq.index == `IDX_BASIC_CONTROL) ? ctrlWord :
                      (mgmtReq.index == `IDX_BASIC_STATUS)  ? statusWord :
                      (mgmtReq.index == `IDX_IDENT_HIGH)    ? idHigh_q :
                      (mgmtReq.index == `IDX_IDENT_LOW)     ? idLow_q :
                      (mgmtReq.index == `IDX_AUTONEG_ADV)   ? adv_q :
                      16'h0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= mgmtReq.rd;
      if (mgmtReq.rd) begin
        rdData <= readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver control and pause resolution

  logic [1:0] advPause;
  logic       pauseSymRes;
  logic       pauseAsymRes;
  xcvr_ctrl_t xcvr_d;

  assign advPause     = adv_q[11:10];
  assign pauseSymRes  = ctrl_q.anEnable && anDoneSync && advPause[0] && partnerPause[0];
  assign pauseAsymRes = ctrl_q.anEnable && anDoneSync && advPause[1] && partnerPause[1] &&
                        !pauseSymRes;

  assign xcvr_d.softResetActive = !srIdle;
  assign xcvr_d.loopback        = ctrl_q.loopback;
  assign xcvr_d.speed100        = ctrl_q.anEnable ? anSpeedSync : ctrl_q.speed100;
  assign xcvr_d.fullDuplex      = ctrl_q.anEnable ? anDuplexSync : ctrl_q.fullDuplex;
  assign xcvr_d.anEnable        = ctrl_q.anEnable;
  assign xcvr_d.powerDown       = ctrl_q.powerDown;
  assign xcvr_d.collisionTest   = ctrl_q.colTest;
  assign xcvr_d.anRestart       = anRestart_q && ctrl_q.anEnable;
  assign xcvr_d.pauseSym        = pauseSymRes;
  assign xcvr_d.pauseAsym       = pauseAsymRes;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xcvrCtrl   <= '0;
      advertWord <= `ADV_RESET_VALUE;
    end else begin
      xcvrCtrl   <= xcvr_d;
      advertWord <= adv_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_soft_reset_hold: assert property (
    srStart |=> (!srIdle) [*8])
    else $error("soft reset ended too early");

  a_soft_reset_end: assert property (
    srStart |-> ##[1:1000] srIdle)
    else $error("soft reset never cleared");

  a_ctrl_defaults: assert property (
    srDone |=> (ctrl_q == basic_ctrl_t'(`CTRL_RESET_VALUE)) && (adv_q == `ADV_RESET_VALUE))
    else $error("soft reset did not restore defaults");

  a_loopback_follow: assert property (
    (wrCtrl && !srStart) |=> ##1 (xcvrCtrl.loopback == $past(mgmtReq.data[14], 2)))
    else $error("loopback output wrong after write");

  a_speed_override: assert property (
    ##1 (xcvrCtrl.speed100 == ($past(ctrl_q.anEnable) ? $past(anSpeedSync)
                                                       : $past(ctrl_q.speed100))))
    else $error("speed select not overridden correctly");

  a_duplex_override: assert property (
    ##1 (xcvrCtrl.fullDuplex == ($past(ctrl_q.anEnable) ? $past(anDuplexSync)
                                                         : $past(ctrl_q.fullDuplex))))
    else $error("duplex select not overridden correctly");

  a_restart_clear: assert property (
    anRestart_d |=> anRestart_q ##1 (!anRestart_q || $past(anRestart_d)))
    else $error("restart bit did not self-clear");

  a_jabber_latch: assert property (
    (jabberSync && !rdStatus) ##1 (!rdStatus) [*3] |-> latch_q[1])
    else $error("jabber flag not held");

  a_link_latch: assert property (
    !linkSync ##1 !rdStatus |-> !latch_q[0])
    else $error("link loss not held");

  a_status_read: assert property (
    (mgmtReq.rd && mgmtReq.index == `IDX_BASIC_STATUS) |=>
      rdValid && (rdData[15:11] == 5'h0F) && rdData[3] && rdData[0])
    else $error("status fixed bits wrong");

  a_pause_single: assert property (
    !(xcvrCtrl.pauseSym && xcvrCtrl.pauseAsym))
    else $error("both pause settings active");

  a_adv_write: assert property (
    wrAdv |=> adv_q == ($past(mgmtReq.data) & `ADV_WRITE_MASK))
    else $error("advertisement write not stored");

  c_soft_reset: cover property (srStart ##[1:1000] srDone);
  c_restart: cover property (xcvrCtrl.anRestart);
  c_link_loss_read: cover property (!latch_q[0] ##1 rdStatus ##1 latch_q[0]);
  c_pause_both: cover property ((advPause == `PAUSE_BOTH) && pauseSymRes);

endmodule

// ==== mgmt_host_model.sv ====
`timescale 1ns/1ps
module mgmt_host_model
  import phy_mgmt_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Host request
  input  wire logic        start,
  input  wire logic        doWrite,
  input  wire logic [4:0]  idx,
  input  wire logic [15:0] wdata,
  // Management access
  output mgmt_req_t        mgmtReq
);
  logic [15:0] idleData_q = 16'hA5A5;
  logic [15:0] busData;

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset write carries zeros in every other bit
  assign busData = (doWrite && (idx == 5'h00) && wdata[15]) ? 16'h8000 : wdata;

  // Released data lines show a changing pattern
  always @(posedge mclk) begin
    idleData_q <= ~idleData_q;
  end

  // Registers reached by index only
  assign mgmtReq = start ? {~doWrite, doWrite, idx, busData}
                         : {2'b00, ~idx, idleData_q};
endmodule

// ==== phy_basic_mgmt_registers_tb.sv ====
`timescale 1ns/1ps
module phy_basic_mgmt_registers_tb;
  import phy_mgmt_pkg::*;
  localparam int          SR_CYC = 12;
  // Arbitrary identifier values
  localparam logic [15:0] ID_HI  = 16'hA5C3;
  localparam logic [15:0] ID_LO  = 16'h3C5A;

  logic        mclk     = 1'b0;
  logic        rst_n    = 1'b0;
  logic        start    = 1'b0;
  logic        doWrite  = 1'b0;
  logic [4:0]  idx      = 5'h00;
  logic [15:0] wdata    = 16'h0000;
  logic        linkUp   = 1'b0;
  logic        jabber   = 1'b0;
  logic        rFault   = 1'b0;
  logic        anDone   = 1'b0;
  logic        anSpd    = 1'b0;
  logic        anFdx    = 1'b0;
  logic [1:0]  pPause   = 2'h0;
  mgmt_req_t   mgmtReq;
  logic [15:0] rdData;
  logic        rdValid;
  xcvr_ctrl_t  xcvrCtrl;
  logic [15:0] advertWord;
  logic [15:0] expQ[$];
  int          err_count  = 0;
  int          n_compared = 0;
  int          nRestart   = 0;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [15:0] r3;

  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  mgmt_host_model host (
    .mclk    (mclk),
    .start   (start),
    .doWrite (doWrite),
    .idx     (idx),
    .wdata   (wdata),
    .mgmtReq (mgmtReq)
  );

  phy_basic_mgmt_registers #(
    .SOFT_RESET_CYCLES (SR_CYC),
    .IDENT_HIGH_RESET  (ID_HI),
    .IDENT_LOW_RESET   (ID_LO)
  ) uut (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .mgmtReq         (mgmtReq),
    .rdData          (rdData),
    .rdValid         (rdValid),
    .linkUpPin       (linkUp),
    .jabberPin       (jabber),
    .remoteFaultPin  (rFault),
    .anCompletePin   (anDone),
    .anSpeed100Pin   (anSpd),
    .anFullDuplexPin (anFdx),
    .partnerPausePin (pPause),
    .xcvrCtrl        (xcvrCtrl),
    .advertWord      (advertWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: control bit %b, wanted %b", $time, got, exp);
    end
  endtask

  // One request; for a read the data argument is the expected word
  task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
    start = 1'b1;
    doWrite = w;
    idx = i;
    wdata = d;
    if (!w) expQ.push_back(d);
    @(negedge mclk);
  endtask

  task automatic idle(input int n);
    start = 1'b0;
    repeat (n) @(negedge mclk);
  endtask

  task automatic print_verdict;
    if (expQ.size() != 0) begin
      err_count++;
      $display("unexpected at %0t: read results missing", $time);
    end
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read results against the oldest note
  always @(negedge mclk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("unexpected at %0t: read result with none pending", $time);
      end else begin
        check_word(rdData, expQ.pop_front());
      end
    end
  end

  always @(negedge mclk) begin
    if (xcvrCtrl.anRestart === 1'b1) nRestart++;
  end

  initial begin
    repeat (2000) @(posedge mclk);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8192));
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    acc(1'b0, 5'h00, 16'h3000);
    acc(1'b0, 5'h04, 16'h01E1);
    acc(1'b0, 5'h02, ID_HI);
    acc(1'b0, 5'h03, ID_LO);
    acc(1'b0, 5'h07, 16'h0000);
    linkUp = 1'b1;
    anDone = 1'b1;
    anSpd = 1'b1;
    anFdx = 1'b1;
    idle(4);
    acc(1'b0, 5'h01, 16'h7829);
    acc(1'b0, 5'h01, 16'h782D);
    jabber = 1'b1;
    rFault = 1'b1;
    linkUp = 1'b0;
    idle(3);
    jabber = 1'b0;
    rFault = 1'b0;
    linkUp = 1'b1;
    idle(4);
    acc(1'b0, 5'h01, 16'h783B);
    acc(1'b0, 5'h01, 16'h782D);
    acc(1'b1, 5'h01, 16'h0000);
    acc(1'b0, 5'h01, 16'h782D);
    // Manual speed and duplex with negotiation off
    acc(1'b1, 5'h00, 16'h4180);
    idle(3);
    check_bit(xcvrCtrl.loopback, 1'b1);
    check_bit(xcvrCtrl.speed100, 1'b0);
    check_bit(xcvrCtrl.fullDuplex, 1'b1);
    check_bit(xcvrCtrl.collisionTest, 1'b1);
    check_bit(xcvrCtrl.anEnable, 1'b0);
    // Negotiation already off before power-down
    acc(1'b1, 5'h00, 16'h2980);
    idle(3);
    check_bit(xcvrCtrl.powerDown, 1'b1);
    check_bit(xcvrCtrl.speed100, 1'b1);
    acc(1'b0, 5'h00, 16'h2980);
    // Negotiation on with restart
    acc(1'b1, 5'h00, 16'h1200);
    idle(1);
    acc(1'b0, 5'h00, 16'h1000);
    idle(3);
    check_bit(xcvrCtrl.fullDuplex, 1'b1);
    check_bit(xcvrCtrl.powerDown, 1'b0);
    check_bit(nRestart == 1, 1'b1);
    // Identifier and advertisement writes
    r1 = 16'($urandom);
    r2 = 16'($urandom);
    r3 = 16'($urandom) | 16'h0C00;
    acc(1'b1, 5'h02, r1);
    acc(1'b1, 5'h03, r2);
    acc(1'b1, 5'h04, r3);
    acc(1'b0, 5'h02, r1);
    acc(1'b0, 5'h03, r2);
    acc(1'b0, 5'h04, r3 & 16'hBFFF);
    // Both pause kinds advertised
    pPause = 2'h3;
    idle(5);
    check_bit(xcvrCtrl.pauseSym, 1'b1);
    check_bit(xcvrCtrl.pauseAsym, 1'b0);
    check_word(advertWord, r3 & 16'hBFFF);
    pPause = 2'h2;
    idle(5);
    check_bit(xcvrCtrl.pauseSym, 1'b0);
    check_bit(xcvrCtrl.pauseAsym, 1'b1);
    // Soft reset keeps identifiers
    acc(1'b1, 5'h00, 16'hFFFF);
    idle(3);
    check_bit(xcvrCtrl.softResetActive, 1'b1);
    // Control writes are dropped while the reset runs
    acc(1'b1, 5'h00, 16'h4000);
    acc(1'b0, 5'h00, 16'h9000);
    idle(SR_CYC + 4);
    check_bit(xcvrCtrl.softResetActive, 1'b0);
    check_word(advertWord, 16'h01E1);
    acc(1'b0, 5'h00, 16'h3000);
    acc(1'b0, 5'h04, 16'h01E1);
    acc(1'b0, 5'h02, r1);
    idle(3);
    print_verdict;
  end
endmodule
